// ### hw/pirq_pkg.sv
// Purpose: Constants, register map and types of the peripheral interrupt request flag block
// Assumes: AHB-Lite register access, one 40 MHz clock mclk, asynchronous active-low reset
// Notes: Index 0 of every per-register array is request/enable register 2, index 3 is register 5

`default_nettype none

package pirq_pkg;

  localparam int NUM_REQ = 4;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_IRQ_GLOBAL_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_PERIPH_IRQ_ENABLE_2 = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PERIPH_IRQ_ENABLE_3 = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_PERIPH_IRQ_ENABLE_4 = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_PERIPH_IRQ_ENABLE_5 = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_PERIPH_IRQ_REQUEST_2 = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_PERIPH_IRQ_REQUEST_3 = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_PERIPH_IRQ_REQUEST_4 = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_PERIPH_IRQ_REQUEST_5 = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_CLEAR = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_ENABLE = 8'h2c;

  ////////////////////////////////////////////////////////////////////////////
  // Global control fields
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int PERIPH_IRQ_ENABLE_BIT = 6;

  // Flag positions within the request registers
  localparam int OSC_FAIL_FLAG_BIT = 7;
  localparam int CMP2_FLAG_BIT = 6;
  localparam int CMP1_FLAG_BIT = 5;
  localparam int BUS_COLLISION_FLAG_BIT = 3;
  localparam int TIMER6_MATCH_FLAG_BIT = 2;
  localparam int TIMER4_MATCH_FLAG_BIT = 1;
  localparam int CAPCOMP2_FLAG_BIT = 0;
  localparam int ANGULAR_TIMER_FLAG_BIT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Implemented and software-writable bits, index 0 is register 2
  // Register 2: bit 4 absent; 3: bits 7-6 absent; 4: all; 5: bit 3 absent
  localparam logic [NUM_REQ-1:0][DATA_W-1:0] REQ_IMPL_MASK = {8'hf7, 8'hff, 8'h3f, 8'hef};
  // Register 5 bit 2 is hardware-set only
  localparam logic [NUM_REQ-1:0][DATA_W-1:0] REQ_WRITE_MASK = {8'hf3, 8'hff, 8'h3f, 8'hef};
  localparam logic [NUM_REQ-1:0][DATA_W-1:0] ENA_IMPL_MASK = {8'hf7, 8'hff, 8'h3f, 8'hef};
  localparam logic [DATA_W-1:0] GLOBAL_IMPL_MASK = 8'hc0;
  localparam logic [DATA_W-1:0] FLAG_RESET = 8'h00;
  localparam logic [NUM_REQ-1:0] EVENT_RESET = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Bus constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] HRDATA_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WRITE,
    PH_READ
  } pirq_phase_type;

endpackage

`default_nettype wire

// ### hw/pirq_bank_if.sv
// Purpose: Carrier between the bus front end and the request flag bank
// Assumes: Single clock domain
// Notes: Index 0 is request register 2
`timescale 1ns/1ps
`default_nettype none

interface pirq_bank_if;
  logic [pirq_pkg::NUM_REQ-1:0] wr_sel;
  logic [pirq_pkg::DATA_W-1:0] wdata;
  logic [pirq_pkg::NUM_REQ-1:0][pirq_pkg::DATA_W-1:0] event_in;
  logic [pirq_pkg::NUM_REQ-1:0][pirq_pkg::DATA_W-1:0] flag;
  logic [pirq_pkg::NUM_REQ-1:0] hw_set;

  modport bank (input wr_sel, input wdata, input event_in, output flag, output hw_set);
  modport ctrl (output wr_sel, output wdata, output event_in, input flag, input hw_set);
endinterface

`default_nettype wire

// ### hw/pirq_flag_bank.sv
// Purpose: Request flag registers 2 to 5
// Assumes: Event inputs are one-cycle or level requests synchronous to mclk
// Notes: A hardware event in the cycle of a software write wins over the written value
`timescale 1ns/1ps
`default_nettype none

module pirq_flag_bank (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Front end
  pirq_bank_if.bank bank
);

  ////////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < pirq_pkg::NUM_REQ; i++) begin : g_req
      logic [pirq_pkg::DATA_W-1:0] next_flag;
      logic [pirq_pkg::DATA_W-1:0] hw_bits;

      assign hw_bits = bank.event_in[i] & pirq_pkg::REQ_IMPL_MASK[i];
      assign bank.hw_set[i] = |hw_bits;

      always_comb begin
        next_flag = bank.flag[i];
        if (bank.wr_sel[i]) begin
          // Read-only and absent bits keep their value
          next_flag = (bank.wdata & pirq_pkg::REQ_WRITE_MASK[i]) |
                      (bank.flag[i] & ~pirq_pkg::REQ_WRITE_MASK[i]);
        end
        // Set ignores every enable; set beats a same-cycle clear
        next_flag = (next_flag | hw_bits) & pirq_pkg::REQ_IMPL_MASK[i];
      end

      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          bank.flag[i] <= pirq_pkg::FLAG_RESET;
        end else begin
          bank.flag[i] <= next_flag;
        end
      end
    end
  endgenerate

endmodule // pirq_flag_bank

`default_nettype wire

// ### hw/pirq_top.sv
// Purpose: Peripheral interrupt request flags with enables and AHB-Lite register access
// Assumes: Single AHB-Lite master, word transfers, inputs synchronous to mclk
// Notes: Reads take one wait state so a read right after a write sees the new value
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pirq_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Register 2 events
  input wire logic osc_fail_event,
  input wire logic cmp2_event,
  input wire logic cmp1_event,
  input wire logic bus_collision_event,
  input wire logic timer6_match_event,
  input wire logic timer4_match_event,
  input wire logic capcomp2_event,
  // Register 3 events
  input wire logic waveform_gen_event,
  input wire logic zero_cross_event,
  input wire logic [3:0] logic_cell_event,
  // Register 4 events
  input wire logic scanner_event,
  input wire logic checksum_event,
  input wire logic [2:0] meas2_event,
  input wire logic [2:0] meas1_event,
  // Register 5 events
  input wire logic timer3_gate_event,
  input wire logic timer3_overflow_event,
  input wire logic timer5_gate_event,
  input wire logic timer5_overflow_event,
  input wire logic angular_timer_event,
  input wire logic loop_ctrl_error_event,
  input wire logic loop_ctrl_done_event,
  // Interrupt outputs
  output logic periph_irq,
  output logic event_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Internal state
  pirq_bank_if bank_if ();

  pirq_pkg::pirq_phase_type phase;
  logic [pirq_pkg::ADDR_W-1:0] addr_q;
  logic [pirq_pkg::DATA_W-1:0] irq_global_control;
  logic [pirq_pkg::NUM_REQ-1:0][pirq_pkg::DATA_W-1:0] periph_irq_enable;
  logic [pirq_pkg::NUM_REQ-1:0] event_status;
  logic [pirq_pkg::NUM_REQ-1:0] event_enable;
  logic [pirq_pkg::DATA_W-1:0] wbyte;
  logic accept;
  logic wr_active;
  logic [31:0] next_hrdata;
  logic [pirq_pkg::NUM_REQ-1:0] wr_ena_sel;
  logic [pirq_pkg::NUM_REQ-1:0] wr_req_sel;
  logic any_enabled;

  ////////////////////////////////////////////////////////////////////////////
  // Event routing into flag positions
  assign bank_if.event_in[0] = {osc_fail_event, cmp2_event, cmp1_event, 1'b0,
                                bus_collision_event, timer6_match_event,
                                timer4_match_event, capcomp2_event};
  assign bank_if.event_in[1] = {2'h0, waveform_gen_event, zero_cross_event,
                                logic_cell_event};
  assign bank_if.event_in[2] = {scanner_event, checksum_event, meas2_event,
                                meas1_event};
  assign bank_if.event_in[3] = {timer3_gate_event, timer3_overflow_event,
                                timer5_gate_event, timer5_overflow_event, 1'b0,
                                angular_timer_event, loop_ctrl_error_event,
                                loop_ctrl_done_event};

  pirq_flag_bank u_bank (
    .mclk(mclk),
    .arst_n(arst_n),
    .bank(bank_if.bank)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase
  assign accept = hsel & hready & (htrans == pirq_pkg::HTRANS_NONSEQ);
  assign wr_active = (phase == pirq_pkg::PH_WRITE);
  assign wbyte = hwdata[pirq_pkg::DATA_W-1:0];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= pirq_pkg::PH_IDLE;
      addr_q <= pirq_pkg::ADDR_IRQ_GLOBAL_CONTROL;
    end else begin
      if (accept) begin
        addr_q <= haddr[pirq_pkg::ADDR_W-1:0];
        phase <= hwrite ? pirq_pkg::PH_WRITE : pirq_pkg::PH_READ;
      end else begin
        phase <= pirq_pkg::PH_IDLE;
      end
    end
  end

  // One wait state for reads only; writes complete with zero wait states
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !(accept && !hwrite);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hresp <= pirq_pkg::HRESP_OKAY;
    end else begin
      hresp <= pirq_pkg::HRESP_OKAY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  always_comb begin
    wr_ena_sel = '0;
    wr_req_sel = '0;
    if (wr_active) begin
      unique case (addr_q)
        pirq_pkg::ADDR_PERIPH_IRQ_ENABLE_2: wr_ena_sel = 4'h1;
        pirq_pkg::ADDR_PERIPH_IRQ_ENABLE_3: wr_ena_sel = 4'h2;
        pirq_pkg::ADDR_PERIPH_IRQ_ENABLE_4: wr_ena_sel = 4'h4;
        pirq_pkg::ADDR_PERIPH_IRQ_ENABLE_5: wr_ena_sel = 4'h8;
        pirq_pkg::ADDR_PERIPH_IRQ_REQUEST_2: wr_req_sel = 4'h1;
        pirq_pkg::ADDR_PERIPH_IRQ_REQUEST_3: wr_req_sel = 4'h2;
        pirq_pkg::ADDR_PERIPH_IRQ_REQUEST_4: wr_req_sel = 4'h4;
        pirq_pkg::ADDR_PERIPH_IRQ_REQUEST_5: wr_req_sel = 4'h8;
        // Unmapped and non-bank addresses: nothing selected here
        default: wr_req_sel = '0;
      endcase
    end
  end

  assign bank_if.wr_sel = wr_req_sel;
  assign bank_if.wdata = wbyte;

  ////////////////////////////////////////////////////////////////////////////
  // Global control
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_global_control <= pirq_pkg::FLAG_RESET;
    end else if (wr_active && addr_q == pirq_pkg::ADDR_IRQ_GLOBAL_CONTROL) begin
      irq_global_control <= wbyte & pirq_pkg::GLOBAL_IMPL_MASK;
    end
  end

  // Enable registers; they never touch the flags
  genvar e;
  generate
    for (e = 0; e < pirq_pkg::NUM_REQ; e++) begin : g_ena
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          periph_irq_enable[e] <= pirq_pkg::FLAG_RESET;
        end else if (wr_ena_sel[e]) begin
          periph_irq_enable[e] <= wbyte & pirq_pkg::ENA_IMPL_MASK[e];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Block event status: one sticky bit per request register, set by any hardware set
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      event_status <= pirq_pkg::EVENT_RESET;
    end else begin
      // Set wins over a write-one clear in the same cycle
      if (wr_active && addr_q == pirq_pkg::ADDR_EVENT_CLEAR) begin
        event_status <= (event_status & ~wbyte[pirq_pkg::NUM_REQ-1:0]) | bank_if.hw_set;
      end else begin
        event_status <= event_status | bank_if.hw_set;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      event_enable <= pirq_pkg::EVENT_RESET;
    end else if (wr_active && addr_q == pirq_pkg::ADDR_EVENT_ENABLE) begin
      event_enable <= wbyte[pirq_pkg::NUM_REQ-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt outputs, registered, one cycle behind the flags
  always_comb begin
    any_enabled = 1'b0;
    for (int r = 0; r < pirq_pkg::NUM_REQ; r++) begin
      any_enabled = any_enabled | (|(bank_if.flag[r] & periph_irq_enable[r]));
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      periph_irq <= 1'b0;
    end else begin
      // Needs flag, its enable, and both global bits
      periph_irq <= any_enabled &
                    irq_global_control[pirq_pkg::PERIPH_IRQ_ENABLE_BIT] &
                    irq_global_control[pirq_pkg::GLOBAL_IRQ_ENABLE_BIT];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      event_irq <= 1'b0;
    end else begin
      event_irq <= |(event_status & event_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; absent bits and unmapped offsets read zero
  always_comb begin
    next_hrdata = '0;
    unique case (addr_q)
      pirq_pkg::ADDR_IRQ_GLOBAL_CONTROL: next_hrdata[7:0] = irq_global_control;
      pirq_pkg::ADDR_PERIPH_IRQ_ENABLE_2: next_hrdata[7:0] = periph_irq_enable[0];
      pirq_pkg::ADDR_PERIPH_IRQ_ENABLE_3: next_hrdata[7:0] = periph_irq_enable[1];
      pirq_pkg::ADDR_PERIPH_IRQ_ENABLE_4: next_hrdata[7:0] = periph_irq_enable[2];
      pirq_pkg::ADDR_PERIPH_IRQ_ENABLE_5: next_hrdata[7:0] = periph_irq_enable[3];
      pirq_pkg::ADDR_PERIPH_IRQ_REQUEST_2: next_hrdata[7:0] = bank_if.flag[0];
      pirq_pkg::ADDR_PERIPH_IRQ_REQUEST_3: next_hrdata[7:0] = bank_if.flag[1];
      pirq_pkg::ADDR_PERIPH_IRQ_REQUEST_4: next_hrdata[7:0] = bank_if.flag[2];
      pirq_pkg::ADDR_PERIPH_IRQ_REQUEST_5: next_hrdata[7:0] = bank_if.flag[3];
      pirq_pkg::ADDR_EVENT_STATUS: next_hrdata[3:0] = event_status;
      pirq_pkg::ADDR_EVENT_ENABLE: next_hrdata[3:0] = event_enable;
      default: next_hrdata = '0;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= pirq_pkg::HRDATA_RESET;
    end else if (phase == pirq_pkg::PH_READ) begin
      hrdata <= next_hrdata;
    end
  end

endmodule // pirq_top

`default_nettype wire

// ### verif/pirq_chk.sv
// Purpose: Port-level properties of the peripheral interrupt flag block
// Assumes: One AHB-Lite master, hready tied to hreadyout
// Notes: Register contents are judged by the bench, not here
`timescale 1ns/1ps
`default_nettype none

module pirq_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Interrupts
  input wire logic periph_irq,
  input wire logic event_irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  logic wr_dp;
  wire logic taken = hsel && hready && htrans == pirq_pkg::HTRANS_NONSEQ;
  ////////////////////////////////////////////////////////////////////////////
  // Marks the write data phase, so interrupt drops can be traced to a write
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_dp <= 1'b0;
    end else begin
      wr_dp <= taken && hwrite;
    end
  end
  sequence s_rd_taken;
    taken && !hwrite;
  endsequence
  sequence s_wait_ready;
    !hreadyout ##1 hreadyout;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  property p_read_wait;
    s_rd_taken |=> s_wait_ready;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read lacks its single wait state");
  property p_wait_cause;
    !hreadyout |-> $past(taken && !hwrite);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("wait state without a read");
  property p_single_wait;
    !hreadyout |=> hreadyout;
  endproperty
  a_single_wait: assert property (p_single_wait) else $error("wait state longer than one cycle");
  property p_okay;
    hresp == pirq_pkg::HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_upper_zero;
    hrdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("read data upper bits set");
  property p_rdata_hold;
    !$stable(hrdata) |-> !$past(hreadyout);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed outside a read");
  property p_pirq_fall;
    $fell(periph_irq) |-> $past(wr_dp, 2);
  endproperty
  a_pirq_fall: assert property (p_pirq_fall) else $error("peripheral interrupt dropped without a write");
  property p_eirq_fall;
    $fell(event_irq) |-> $past(wr_dp, 2);
  endproperty
  a_eirq_fall: assert property (p_eirq_fall) else $error("event interrupt dropped without a write");
endmodule // pirq_chk

bind pirq_top pirq_chk chk (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .periph_irq(periph_irq),
  .event_irq(event_irq));

`default_nettype wire

// ### verif/pirq_event_src.sv
// Purpose: On-chip event sources facing the flag block
// Assumes: Events synchronous to mclk, idle low
// Notes: One byte per request register, register 2 in bits 7:0
`timescale 1ns/1ps
`default_nettype none

module pirq_event_src (
  // Clock
  input wire logic mclk,
  // Event lines
  output logic [31:0] ev
);
  initial ev = 32'h0000_0000;
  // A slow source holds its line for several cycles; flags must still set once
  task automatic pulse(input logic [31:0] pat, input int hold);
    @(posedge mclk);
    ev <= pat;
    repeat (hold) @(posedge mclk);
    ev <= 32'h0000_0000;
  endtask
endmodule // pirq_event_src

`default_nettype wire

// ### verif/pirq_bench.sv
// Purpose: Self-checking bench of the peripheral interrupt flag block
// Assumes: Single AHB-Lite master, word transfers
// Notes: Inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ps
`default_nettype none

module pirq_bench;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, periph_irq, event_irq;
  logic [31:0] hrdata, ev;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  localparam logic [3:0][7:0] IMPL = {8'hf7, 8'hff, 8'h3f, 8'hef};
  localparam logic [3:0][7:0] WMASK = {8'hf3, 8'hff, 8'h3f, 8'hef};
  always #12.5 mclk = ~mclk;
  pirq_event_src src (.mclk(mclk), .ev(ev));
  pirq_top uut (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .osc_fail_event(ev[7]), .cmp2_event(ev[6]), .cmp1_event(ev[5]), .bus_collision_event(ev[3]),
    .timer6_match_event(ev[2]), .timer4_match_event(ev[1]), .capcomp2_event(ev[0]),
    .waveform_gen_event(ev[13]), .zero_cross_event(ev[12]), .logic_cell_event(ev[11:8]),
    .scanner_event(ev[23]), .checksum_event(ev[22]), .meas2_event(ev[21:19]), .meas1_event(ev[18:16]),
    .timer3_gate_event(ev[31]), .timer3_overflow_event(ev[30]), .timer5_gate_event(ev[29]),
    .timer5_overflow_event(ev[28]), .angular_timer_event(ev[26]), .loop_ctrl_error_event(ev[25]),
    .loop_ctrl_done_event(ev[24]), .periph_irq(periph_irq), .event_irq(event_irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Outputs are registered, so reading them right after the edge gives the sampled value
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= pirq_pkg::HTRANS_NONSEQ;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, a, d, t);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] t;
    bus(1'b0, a, 32'h0, t);
    check(t, exp);
  endtask
  task automatic irq_chk(input logic [1:0] exp);
    repeat (2) @(posedge mclk);
    check({30'h0, event_irq, periph_irq}, {30'h0, exp});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int a = 0; a <= 'h2c; a += 4) begin
      rd_chk(8'(a), 32'h0);
    end
    irq_chk(2'b00);
  endtask
  // Angular flag cannot be cleared by software, so it sticks once set
  task automatic t_map;
    logic [7:0] a, b, s;
    for (int i = 0; i < 32; i++) begin
      a = 8'h14 + 8'(4 * (i / 8));
      b = (8'h01 << (i % 8)) & IMPL[i / 8];
      s = (i > 26) ? 8'h04 : 8'h00;
      src.pulse(32'h1 << i, 1 + i / 16);
      rd_chk(a, {24'h0, b | s});
      rd_chk(8'h24, (b != 8'h00) ? 32'h1 << (i / 8) : 32'h0);
      wr(a, 32'h0);
      wr(8'h28, 32'hf);
      rd_chk(a, (i >= 26) ? 32'h4 : 32'h0);
    end
  endtask
  task automatic t_regs;
    for (int r = 0; r < 4; r++) begin
      wr(8'h14 + 8'(4 * r), 32'hffff_ffff);
      rd_chk(8'h14 + 8'(4 * r), {24'h0, WMASK[r]});
      wr(8'h04 + 8'(4 * r), 32'hffff_ffff);
      rd_chk(8'h04 + 8'(4 * r), {24'h0, IMPL[r]});
      wr(8'h14 + 8'(4 * r), 32'h0);
      wr(8'h04 + 8'(4 * r), 32'h0);
      rd_chk(8'h14 + 8'(4 * r), 32'h0);
    end
    wr(8'h00, 32'hff);
    rd_chk(8'h00, 32'hc0);
    wr(8'h00, 32'h0);
    wr(8'h40, 32'hff);
    rd_chk(8'h40, 32'h0);
    wr(8'h24, 32'hf);
    rd_chk(8'h24, 32'h0);
  endtask
  task automatic t_irq;
    wr(8'h14, 32'h0);
    wr(8'h04, 32'h01);
    wr(8'h00, 32'h40);
    src.pulse(32'h1, 1);
    irq_chk(2'b00);
    wr(8'h00, 32'hc0);
    irq_chk(2'b01);
    wr(8'h00, 32'h80);
    irq_chk(2'b00);
    wr(8'h00, 32'hc0);
    wr(8'h04, 32'h0);
    irq_chk(2'b00);
    rd_chk(8'h14, 32'h01);
    wr(8'h2c, 32'h1);
    wr(8'h04, 32'h01);
    irq_chk(2'b11);
    wr(8'h28, 32'h1);
    irq_chk(2'b01);
    wr(8'h14, 32'h0);
    irq_chk(2'b00);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_map();
    arst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_regs();
    t_irq();
    report_and_stop();
  end
endmodule // pirq_bench

`default_nettype wire
